/* File: src/rcp_pkg.sv */
// Constants, register layout and state types of the serial command port.
// Assumes one core clock; the top passes its rate in as a parameter.
package rcp_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int OVS = 16; // Receiver samples per bit
  localparam logic [3:0] PH_MID = 4'h7;
  localparam logic [3:0] PH_LAST = 4'hf;
  localparam int RATES = 10;
  localparam int BAUD [RATES] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600,
                                  115200};
  localparam logic [3:0] RATE_DEFAULT = 4'h5;
  localparam logic [7:0] LF = 8'h0a;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_TXD = 8'h08;
  localparam logic [7:0] OFF_RXD = 8'h0c;
  localparam int TX_LAST = 8;
  localparam int ST_FERR = 4;
  localparam int ST_PERR = 5;
  localparam int ST_OVR = 6;
  localparam int ST_MSG = 7;
  typedef struct packed {
    logic cmd;
    logic flow;
    logic [1:0] par;
    logic eight;
    logic [3:0] rate;
    logic en;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = '{cmd: 1'b1, flow: 1'b0, par: 2'h0, eight: 1'b1,
                                   rate: RATE_DEFAULT, en: 1'b1};
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef enum logic {T_IDLE, T_SHIFT} tx_state_t;
  typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} rx_state_t;
  typedef struct packed {
    ctrl_t ctrl;
    logic rx_s1;
    logic rx_s2;
    logic cts_s1;
    logic cts_s2;
    logic [15:0] os_cnt;
    tx_state_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_ph;
    logic tx;
    logic [7:0] hold;
    logic hold_v;
    logic hold_lf;
    rx_state_t rx_st;
    logic [3:0] rx_ph;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_eom;
    logic ferr;
    logic perr;
    logic ovr;
    logic msg;
    logic rts;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;
  // Oversample divider reload; an out-of-table index falls back to the default
  function automatic logic [15:0] div_of(int clk_hz, logic [3:0] idx);
    int b;
    b = (idx < 4'(RATES)) ? BAUD[idx] : BAUD[RATE_DEFAULT];
    return 16'(clk_hz / (OVS * b) - 1);
  endfunction
endpackage

/* File: src/rs232_command_port.sv */
// Serial command port: APB register slave, transmitter and receiver.
// Assumes rx_i and cts_i are asynchronous pins; APB is on core_clk_i.

// What this block does
// - Ten bit rates, 300 to 115200, by index
// - Rate index resets to 9600 baud
// - Seven or eight data bits, both directions
// - One stop bit; none, even, odd parity
// - Received line feed ends a command message
// - Line feed follows each response's last byte
// - Raw writes go out with no terminator
// - RTS asserted only while reception possible
// - With handshake set, start a character only while host asserts CTS
// - Flow setting: none or hardware handshake
// - New settings act when written, a new rate within one tick
// - Disabled port neither sends nor accepts
module rs232_command_port #(
  parameter int CLK_HZ = rcp_pkg::CLK_HZ
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire rcp_pkg::apb_req_t apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_i,
  input wire logic cts_i,
  output logic tx_o,
  output logic rts_o
);
  // Divider must stay above one and fit its 16-bit counter
  if (CLK_HZ / (rcp_pkg::OVS * rcp_pkg::BAUD[rcp_pkg::RATES - 1]) < 2 ||
      CLK_HZ / (rcp_pkg::OVS * rcp_pkg::BAUD[0]) > 65535) begin : g_bad_clk
    $error("CLK_HZ cannot serve the rate table");
  end

  rcp_pkg::state_t s;
  rcp_pkg::state_t n;
  logic os_tick;
  logic [15:0] div;
  logic [3:0] nb;
  logic [3:0] nrx;
  logic hp;
  logic pb;
  logic [7:0] mask;
  logic [10:0] fr;
  logic [8:0] full;
  logic [7:0] rd;
  logic pexp;
  logic deliver;
  logic acc;
  logic done;
  logic [7:0] stat;

  // Outputs are the registered copies
  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign tx_o = s.tx;
  assign rts_o = s.rts;

  // Frame shape from the live settings
  always_comb begin
    nb = s.ctrl.eight ? 4'h8 : 4'h7;
    hp = (s.ctrl.par == rcp_pkg::PAR_EVEN) || (s.ctrl.par == rcp_pkg::PAR_ODD);
    nrx = nb + {3'h0, hp};
    mask = s.ctrl.eight ? 8'hff : 8'h7f;
    div = rcp_pkg::div_of(CLK_HZ, s.ctrl.rate);
    os_tick = (s.os_cnt == 16'h0000);
    acc = apb_i.psel && apb_i.penable;
    done = acc && s.pready;
    stat = {s.msg, s.ovr, s.perr, s.ferr, s.tx_st == rcp_pkg::T_SHIFT, !s.hold_v,
            s.rx_eom, s.rx_valid};
  end

  // Transmit frame: start low, data LSB first, parity, ones above as stop
  always_comb begin
    pb = (s.ctrl.par == rcp_pkg::PAR_ODD) ^ (^(s.hold & mask));
    fr = 11'h7fe;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nb)) begin
        fr[i + 1] = s.hold[i];
      end
    end
    if (hp) begin
      fr[nb + 4'h1] = pb;
    end
  end

  // Received word realigned to bit zero
  always_comb begin
    full = s.rx_sh >> (4'h9 - nrx);
    rd = s.ctrl.eight ? full[7:0] : {1'b0, full[6:0]};
    pexp = (s.ctrl.par == rcp_pkg::PAR_ODD) ^ (^rd);
  end

  // Next state of the whole port
  always_comb begin
    n = s;
    deliver = 1'b0;
    n.rx_s1 = rx_i;
    n.rx_s2 = s.rx_s1;
    n.cts_s1 = cts_i;
    n.cts_s2 = s.cts_s1;
    // Reload takes the current rate, so a new rate acts within one tick
    n.os_cnt = os_tick ? div : s.os_cnt - 16'h0001;

    // APB: one wait state, answer registered
    n.pready = acc && !s.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    if (acc && !s.pready) begin
      unique case (apb_i.paddr)
        rcp_pkg::OFF_CTRL: n.prdata = 32'(s.ctrl);
        rcp_pkg::OFF_STAT: n.prdata = 32'(stat);
        rcp_pkg::OFF_TXD: n.pslverr = apb_i.pwrite && (s.hold_v || !s.ctrl.en);
        rcp_pkg::OFF_RXD: n.prdata = 32'({s.rx_eom, s.rx_data});
        default: n.pslverr = 1'b1;
      endcase
    end
    if (done && apb_i.pwrite && !s.pslverr) begin
      unique case (apb_i.paddr)
        rcp_pkg::OFF_CTRL: n.ctrl = rcp_pkg::ctrl_t'(apb_i.pwdata[9:0]);
        rcp_pkg::OFF_STAT: begin
          n.ferr = s.ferr && !apb_i.pwdata[rcp_pkg::ST_FERR];
          n.perr = s.perr && !apb_i.pwdata[rcp_pkg::ST_PERR];
          n.ovr = s.ovr && !apb_i.pwdata[rcp_pkg::ST_OVR];
          n.msg = s.msg && !apb_i.pwdata[rcp_pkg::ST_MSG];
        end
        rcp_pkg::OFF_TXD: begin
          n.hold = apb_i.pwdata[7:0];
          n.hold_v = 1'b1;
          // Raw bytes carry no terminator; responses ask for one
          n.hold_lf = apb_i.pwdata[rcp_pkg::TX_LAST] && s.ctrl.cmd;
        end
        default: ;
      endcase
    end
    if (done && !apb_i.pwrite && apb_i.paddr == rcp_pkg::OFF_RXD) begin
      n.rx_valid = 1'b0;
      n.rx_eom = 1'b0;
    end

    // Transmitter; CTS is judged per character, a started frame completes
    unique case (s.tx_st)
      rcp_pkg::T_IDLE: begin
        if (s.ctrl.en && s.hold_v && (!s.ctrl.flow || s.cts_s2)) begin
          n.tx_st = rcp_pkg::T_SHIFT;
          n.tx_sh = fr;
          n.tx_left = nrx + 4'h2;
          n.tx_ph = 4'h0;
          if (s.hold_lf) begin
            n.hold = rcp_pkg::LF;
            n.hold_lf = 1'b0;
          end else begin
            n.hold_v = 1'b0;
          end
        end
      end
      rcp_pkg::T_SHIFT: begin
        if (os_tick) begin
          n.tx_ph = s.tx_ph + 4'h1;
          if (s.tx_ph == rcp_pkg::PH_LAST) begin
            n.tx_sh = {1'b1, s.tx_sh[10:1]};
            n.tx_left = s.tx_left - 4'h1;
            if (s.tx_left == 4'h1) begin
              n.tx_st = rcp_pkg::T_IDLE;
            end
          end
        end
      end
    endcase

    // Receiver: confirm start at mid bit, then sample every bit centre
    unique case (s.rx_st)
      rcp_pkg::R_IDLE: begin
        if (!s.rx_s2) begin
          n.rx_st = rcp_pkg::R_START;
          n.rx_ph = 4'h0;
        end
      end
      rcp_pkg::R_START: begin
        if (os_tick) begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == rcp_pkg::PH_MID) begin
            n.rx_st = s.rx_s2 ? rcp_pkg::R_IDLE : rcp_pkg::R_BITS;
            n.rx_ph = 4'h0;
            n.rx_cnt = 4'h0;
          end
        end
      end
      rcp_pkg::R_BITS: begin
        if (os_tick) begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == rcp_pkg::PH_LAST) begin
            n.rx_sh = {s.rx_s2, s.rx_sh[8:1]};
            n.rx_cnt = s.rx_cnt + 4'h1;
            if (s.rx_cnt == nrx - 4'h1) begin
              n.rx_st = rcp_pkg::R_STOP;
            end
          end
        end
      end
      rcp_pkg::R_STOP: begin
        if (os_tick) begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == rcp_pkg::PH_LAST) begin
            n.rx_st = rcp_pkg::R_IDLE;
            deliver = 1'b1;
          end
        end
      end
    endcase

    // Delivery after the APB clears, so a new event beats a clear
    if (deliver) begin
      n.ferr = n.ferr || !s.rx_s2;
      n.perr = n.perr || (hp && (full[nb] != pexp));
      if (n.rx_valid) begin
        n.ovr = 1'b1; // Older byte kept, newcomer dropped
      end else begin
        n.rx_valid = 1'b1;
        n.rx_data = rd;
        n.rx_eom = s.ctrl.cmd && (rd == rcp_pkg::LF);
        n.msg = n.msg || (s.ctrl.cmd && (rd == rcp_pkg::LF));
      end
    end

    // Disabled: line idles high, pending byte dropped, receiver parked
    if (!s.ctrl.en) begin
      n.tx_st = rcp_pkg::T_IDLE;
      n.hold_v = 1'b0;
      n.hold_lf = 1'b0;
      n.rx_st = rcp_pkg::R_IDLE;
    end
    n.tx = (n.tx_st == rcp_pkg::T_SHIFT) ? n.tx_sh[0] : 1'b1;
    // Only one byte of room, so RTS drops while it is occupied
    n.rts = n.ctrl.flow && n.ctrl.en && !n.rx_valid;
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.ctrl <= rcp_pkg::CTRL_RESET;
      s.tx <= 1'b1;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.cts_s1 <= 1'b0;
      s.cts_s2 <= 1'b0;
    end else if (ce_i) begin
      s <= n;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  rate_reset_a: assert property (
    !$past(rst_b_i) |-> s.ctrl.rate == rcp_pkg::RATE_DEFAULT)
    else $error("rate index not 9600 after reset");

  rts_gate_a: assert property (
    rts_o |-> s.ctrl.flow && s.ctrl.en && !s.rx_valid)
    else $error("rts asserted while unable to accept");

  cts_start_a: assert property (
    ($fell(tx_o) && $past(s.tx_st) == rcp_pkg::T_IDLE && $past(s.ctrl.flow))
    |-> $past(s.cts_s2))
    else $error("frame started without cts");

  stop_high_a: assert property (
    (s.tx_st == rcp_pkg::T_SHIFT && s.tx_left == 4'h1) |-> tx_o)
    else $error("stop bit not high");

  start_low_a: assert property (
    (s.tx_st == rcp_pkg::T_SHIFT && $past(s.tx_st) == rcp_pkg::T_IDLE)
    |-> !tx_o && s.tx_ph == 4'h0)
    else $error("frame did not open with a low start bit");

  lf_append_a: assert property (
    (ce_i && done && apb_i.pwrite && apb_i.paddr == rcp_pkg::OFF_TXD && !s.pslverr &&
     apb_i.pwdata[rcp_pkg::TX_LAST] && s.ctrl.cmd && s.ctrl.en) |=> s.hold_lf && s.hold_v)
    else $error("response byte without line feed pending");

  raw_write_a: assert property (
    (ce_i && done && apb_i.pwrite && apb_i.paddr == rcp_pkg::OFF_TXD && !s.pslverr &&
     !apb_i.pwdata[rcp_pkg::TX_LAST] && s.ctrl.en)
    |=> s.hold_v && !s.hold_lf && s.hold == $past(apb_i.pwdata[7:0]))
    else $error("raw write altered or terminated");

  eom_flag_a: assert property (
    (ce_i && deliver && s.ctrl.cmd && s.ctrl.en && rd == rcp_pkg::LF && !s.rx_valid)
    |=> s.rx_eom && s.msg && s.rx_valid)
    else $error("line feed did not end the message");

  frame_err_a: assert property (
    (ce_i && deliver && !s.rx_s2) |=> s.ferr)
    else $error("low stop bit not flagged");

  quiet_a: assert property (
    (!s.ctrl.en && !$past(s.ctrl.en)) |-> tx_o && s.tx_st == rcp_pkg::T_IDLE && !s.hold_v)
    else $error("disabled port still active");
endmodule

/* File: verif/host_port.sv */
// Host serial port model: sends frames to the port and decodes its frames.
// Assumes the bench sets bit_cyc, nbits and par to match the port first.
module host_port (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o,
  output logic cts_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 32;
  int nbits = 8;
  logic [1:0] par = 2'h0;
  logic [7:0] got[$];
  logic [7:0] rd;
  logic ok;
  int bad = 0;
  // Line idles high; CTS starts low until the host is ready
  initial begin
    rx_o = 1'b1;
    cts_o = 1'b0;
  end
  // Parity over the live data bits only
  function automatic logic pbit(logic [7:0] d);
    return ^(d & (nbits == 8 ? 8'hff : 8'h7f)) ^ (par == rcp_pkg::PAR_ODD);
  endfunction
  // One frame at the shared settings
  task automatic send(logic [7:0] d);
    rx_o <= 1'b0;
    repeat (bit_cyc) @(posedge clk_i);
    for (int i = 0; i < nbits; i++) begin
      rx_o <= d[i];
      repeat (bit_cyc) @(posedge clk_i);
    end
    if (par == rcp_pkg::PAR_EVEN || par == rcp_pkg::PAR_ODD) begin
      rx_o <= pbit(d);
      repeat (bit_cyc) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (bit_cyc) @(posedge clk_i);
  endtask
  // Centre sampling of device frames; bad framing is counted
  always begin
    @(negedge tx_i);
    repeat (bit_cyc / 2) @(posedge clk_i);
    ok = !tx_i;
    rd = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge clk_i);
      rd[i] = tx_i;
    end
    if (par == rcp_pkg::PAR_EVEN || par == rcp_pkg::PAR_ODD) begin
      repeat (bit_cyc) @(posedge clk_i);
      ok = ok && (tx_i === pbit(rd));
    end
    repeat (bit_cyc) @(posedge clk_i);
    ok = ok && (tx_i === 1'b1);
    if (!ok) bad++;
    got.push_back(rd);
  end
endmodule

/* File: verif/testbench.sv */
// Self-checking bench: APB master tasks and a host model on the link.
// Assumes a slow CLK_HZ so that every rate divides to whole ticks.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HZ = 3686400;
  logic clk;
  logic rst_b = 1'b0;
  rcp_pkg::apb_req_t apb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rx, cts, tx, rts, err;
  logic ce = 1'b1;
  logic [31:0] rd;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  rs232_command_port #(.CLK_HZ(HZ)) dut (.core_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
    .apb_i(apb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx),
    .cts_i(cts), .tx_o(tx), .rts_o(rts));
  host_port host (.clk_i(clk), .tx_i(tx), .rx_o(rx), .cts_o(cts));
  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits on pready, then releases for a cycle
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) begin
      fails++;
    end
    rd = prdata;
    err = pslverr;
    apb <= '0;
    @(posedge clk);
  endtask
  // Port and host settings move together
  task automatic cfg(logic [3:0] r, logic e, logic [1:0] p, logic f, logic en);
    host.bit_cyc = HZ / (16 * rcp_pkg::BAUD[r]) * 16;
    host.nbits = e ? 8 : 7;
    host.par = p;
    host.got.delete();
    xfer(1'b1, rcp_pkg::OFF_CTRL, 32'({1'b1, f, p, e, r, en}));
  endtask
  task automatic wait_rx(int n);
    int k;
    k = 0;
    while (host.got.size() < n && k < 14 * n * host.bit_cyc) begin
      @(posedge clk);
      k++;
    end
  endtask
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    xfer(1'b0, rcp_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h22b);
    chk(32'(rts), 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    $display("reset test done");
    for (int r = 5; r < 10; r++) begin
      cfg(4'(r), 1'b1, 2'h0, 1'b0, 1'b1);
      xfer(1'b1, rcp_pkg::OFF_TXD, 32'h0a + 32'(r));
      wait_rx(2);
      chk(32'(host.got.size()), 32'h1);
      chk(32'(host.got[0]), 32'h0a + 32'(r));
    end
    $display("rate test done");
    for (int f = 0; f < 6; f++) begin
      cfg(4'h9, f[0], 2'(f / 2), 1'b0, 1'b1);
      host.send(8'hd3);
      xfer(1'b0, rcp_pkg::OFF_RXD, 32'h0);
      chk(rd, f[0] ? 32'hd3 : 32'h53);
      xfer(1'b0, rcp_pkg::OFF_STAT, 32'h0);
      chk(32'(rd[7:4]), 32'h0);
      xfer(1'b1, rcp_pkg::OFF_TXD, 32'h1c5);
      wait_rx(2);
      chk(32'(host.got[0]), f[0] ? 32'hc5 : 32'h45);
      chk(32'(host.got[1]), 32'(rcp_pkg::LF));
      chk(32'(host.bad), 32'h0);
    end
    host.send(rcp_pkg::LF);
    xfer(1'b0, rcp_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[7:0] & 8'h83), 32'h83);
    xfer(1'b0, rcp_pkg::OFF_RXD, 32'h0);
    chk(rd, 32'h10a);
    // Second byte while one is held is dropped and flagged
    host.send(8'h21);
    host.send(8'h22);
    xfer(1'b0, rcp_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[6]), 32'h1);
    xfer(1'b0, rcp_pkg::OFF_RXD, 32'h0);
    chk(rd, 32'h21);
    xfer(1'b1, rcp_pkg::OFF_STAT, 32'h40);
    xfer(1'b0, rcp_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[6]), 32'h0);
    // Host with the wrong parity sense trips the parity check
    host.par = rcp_pkg::PAR_EVEN;
    host.send(8'h01);
    host.par = rcp_pkg::PAR_ODD;
    xfer(1'b0, rcp_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[5]), 32'h1);
    xfer(1'b0, rcp_pkg::OFF_RXD, 32'h0);
    chk(rd, 32'h01);
    $display("format test done");
    cfg(4'h9, 1'b1, 2'h0, 1'b1, 1'b1);
    chk(32'(rts), 32'h1);
    xfer(1'b1, rcp_pkg::OFF_TXD, 32'h55);
    wait_rx(1);
    chk(32'(host.got.size()), 32'h0);
    host.cts_o <= 1'b1;
    wait_rx(1);
    chk(32'(host.got[0]), 32'h55);
    host.send(8'h12);
    chk(32'(rts), 32'h0);
    xfer(1'b0, rcp_pkg::OFF_RXD, 32'h0);
    chk(32'(rts), 32'h1);
    $display("flow test done");
    cfg(4'h9, 1'b1, 2'h0, 1'b0, 1'b0);
    xfer(1'b1, rcp_pkg::OFF_TXD, 32'h33);
    chk(32'(err), 32'h1);
    host.send(8'h66);
    xfer(1'b0, rcp_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[0]), 32'h0);
    chk(32'(tx), 32'h1);
    $display("disable test done");
    end_sim();
  end
endmodule
